// ### design/block_select_decode.sv
/*
 Finds the erase block holding an address and reports whether it is selected.
 Assumes the select vector holds the small blocks low and the large blocks high.
*/
`timescale 1ns/100ps
`default_nettype none
module block_select_decode
   import flash_ctrl_pkg::*;
(
   input  wire logic [15:0]           addr,
   input  wire logic [NUM_BLOCKS-1:0] select,
   output var  logic                  selected
);
   logic [NUM_BLOCKS-1:0] in_block;

   // Each entry compares against its own address range.
   for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_block
      assign in_block[i] = addr >= BLOCK_FIRST[i] && addr <= BLOCK_LAST[i];
   end

   assign selected = |(in_block & select);
endmodule : block_select_decode
`default_nettype wire

// ### design/flash_block_select_ram_overlay.sv
/*
 Flash block selection, programming mode control and RAM overlay, reached over APB.
 Assumes synchronous pins, one clock, and a CPU address presented once per cycle.
*/
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module flash_block_select_ram_overlay
   import flash_ctrl_pkg::*;
#(
   parameter int ADDR_WIDTH = APB_ADDR_WIDTH
)(
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_WIDTH-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output var  logic [31:0]           prdata,
   output var  logic                  pready,
   output var  logic                  pslverr,
   input  wire pin_state_t            pins,
   input  wire logic                  software_standby,
   input  wire logic                  hardware_standby,
   input  wire logic                  interrupt_request,
   input  wire cpu_access_t           cpu_access,
   output var  logic                  cpu_to_ram,
   output var  logic [15:0]           cpu_mapped_addr,
   output var  logic                  cpu_block_writable,
   output var  logic                  program_active,
   output var  logic                  erase_active,
   output var  logic                  program_verify_active,
   output var  logic                  erase_verify_active,
   output var  logic                  emulation_protect,
   output var  logic                  peripheral_clock_divide,
   output var  logic [1:0]            wait_style,
   output var  logic [1:0]            wait_length,
   output var  logic [NUM_BLOCKS-1:0] block_enable,
   output var  logic                  boot_mode,
   output var  logic                  user_program_mode,
   output var  logic                  flash_disabled
);
   if (ADDR_WIDTH < APB_ADDR_WIDTH) begin : g_bad_width
      $error("paddr too narrow for the register map");
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Register storage and derived conditions.
   logic [3:0]   flash_mode_control;
   logic [7:0]   large_block_select;
   logic [7:0]   small_block_select;
   logic [7:0]   overlay_wait_control;
   logic         mode_zero_latched;
   logic         overlay_triggered;
   flash_op_t    next_flash_op;
   overlay_sel_t overlay_sel;
   logic         vpp;
   logic         clear_flash_regs;
   logic         flash_regs_open;
   logic         overlay_active;
   logic         protect_now;

   assign vpp              = pins.vpp_sense;
   assign overlay_sel      = overlay_sel_t'(overlay_wait_control[OVL_SEL_MSB:OVL_SEL_LSB]);
   assign clear_flash_regs = software_standby | hardware_standby | ~vpp;
   assign flash_regs_open  = vpp & ~flash_disabled;
   assign protect_now      = overlay_sel == OVL_LOW_WINDOW
                           || overlay_sel == OVL_WIDE_WINDOW;
   assign overlay_active   = protect_now
                           || (overlay_sel == OVL_ON_INTERRUPT && overlay_triggered);

   //////////////////////////////////////////////////////////////////////////////////////
   // APB address decode.
   logic [15:0] index;
   logic        aligned;
   logic        hit_flash_mode;
   logic        hit_large;
   logic        hit_small;
   logic        hit_overlay;
   logic        hit_report;
   logic        hit_flash_group;

   assign index           = paddr[17:2];
   assign aligned         = paddr[1:0] == WORD_ALIGN && paddr[ADDR_WIDTH-1:2] == 
                            (ADDR_WIDTH-2)'(index);
   assign hit_flash_mode  = aligned && index == FLASH_MODE_INDEX;
   assign hit_large       = aligned && index == LARGE_BLOCK_INDEX;
   assign hit_small       = aligned && index == SMALL_BLOCK_INDEX;
   assign hit_overlay     = aligned && index == OVERLAY_WAIT_INDEX;
   assign hit_report      = aligned && index == MODE_REPORT_INDEX;
   assign hit_flash_group = hit_flash_mode | hit_large | hit_small;

   //////////////////////////////////////////////////////////////////////////////////////
   // Read data and error for the access phase, formed in the setup cycle.
   logic [7:0] next_read;
   logic       next_error;

   always_comb begin
      next_read  = 8'h00;
      next_error = 1'b0;
      if (hit_flash_group && flash_disabled) begin
         next_read = LOCKED_READ;
      end else if (hit_flash_group && !vpp) begin
         next_read  = LOCKED_READ;
         next_error = ~mode_zero_latched;
      end else if (hit_flash_mode) begin
         next_read                 = {4'h0, flash_mode_control};
         next_read[VPP_STATUS_BIT] = vpp;
      end else if (hit_large) begin
         next_read = large_block_select;
      end else if (hit_small) begin
         next_read = small_block_select;
      end else if (hit_overlay) begin
         next_read = overlay_wait_control;
      end else if (hit_report) begin
         next_read = {6'h00, ~flash_disabled, mode_zero_latched};
      end else begin
         next_error = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & next_error;
         prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, next_read} : 32'h0000_0000;
      end
   end

   logic write_take;
   logic flash_write;

   assign write_take  = psel & penable & pready & pwrite & ~pslverr;
   assign flash_write = write_take & flash_regs_open;

   //////////////////////////////////////////////////////////////////////////////////////
   // Mode pins are caught while reset is held, so the last value before release sticks.
   always_ff @(posedge clock) begin
      if (reset) begin
         boot_mode         <= pins.vpp_sense & pins.mode_one_hv;
         user_program_mode <= pins.vpp_sense & ~pins.mode_one_hv & pins.mode_pin_one;
         flash_disabled    <= ~pins.mode_one_hv & ~pins.mode_pin_one;
         mode_zero_latched <= pins.mode_pin_zero;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Flash control register, program and erase requests.
   always_ff @(posedge clock) begin
      if (reset || clear_flash_regs) begin
         flash_mode_control <= FLASH_MODE_RESET[3:0];
      end else if (flash_write && hit_flash_mode) begin
         flash_mode_control <= pwdata[3:0];
      end
   end

   // Large-block register: upper nibble always ones.
   always_ff @(posedge clock) begin
      if (reset || clear_flash_regs) begin
         large_block_select <= LARGE_BLOCK_RESET;
      end else if (flash_write && hit_large) begin
         large_block_select <= {LARGE_FIXED_BITS, pwdata[3:0]};
      end
   end

   // Small-block register.
   always_ff @(posedge clock) begin
      if (reset || clear_flash_regs) begin
         small_block_select <= SMALL_BLOCK_RESET;
      end else if (flash_write && hit_small) begin
         small_block_select <= pwdata[7:0];
      end
   end

   // Overlay and wait register: software standby leaves it alone.
   always_ff @(posedge clock) begin
      if (reset || hardware_standby) begin
         overlay_wait_control <= OVERLAY_WAIT_RESET;
      end else if (write_take && hit_overlay) begin
         overlay_wait_control <= pwdata[7:0];
      end
   end

   // Interrupt arming of the both-bits overlay.
   always_ff @(posedge clock) begin
      if (reset || hardware_standby || overlay_sel != OVL_ON_INTERRUPT) begin
         overlay_triggered <= 1'b0;
      end else if (interrupt_request && vpp) begin
         overlay_triggered <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Flash operation state; protection refuses program and erase only.
   always_comb begin
      next_flash_op = OP_IDLE;
      if (!clear_flash_regs && flash_regs_open) begin
         case (1'b1)
            flash_mode_control[PROGRAM_BIT]:
               next_flash_op = protect_now ? OP_IDLE : OP_PROGRAM;
            flash_mode_control[ERASE_BIT]:
               next_flash_op = protect_now ? OP_IDLE : OP_ERASE;
            flash_mode_control[PROGRAM_VERIFY_BIT]:
               next_flash_op = OP_PROGRAM_VERIFY;
            flash_mode_control[ERASE_VERIFY_BIT]:
               next_flash_op = OP_ERASE_VERIFY;
            default:
               next_flash_op = OP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         program_active        <= 1'b0;
         erase_active          <= 1'b0;
         program_verify_active <= 1'b0;
         erase_verify_active   <= 1'b0;
      end else begin
         program_active        <= next_flash_op == OP_PROGRAM;
         erase_active          <= next_flash_op == OP_ERASE;
         program_verify_active <= next_flash_op == OP_PROGRAM_VERIFY;
         erase_verify_active   <= next_flash_op == OP_ERASE_VERIFY;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Field outputs taken straight from the registers; emulation_protect is registered from protect_now.
   assign peripheral_clock_divide = overlay_wait_control[CLOCK_DIVIDE_BIT];
   assign wait_style  = overlay_wait_control[WAIT_STYLE_MSB:WAIT_STYLE_LSB];
   assign wait_length = overlay_wait_control[WAIT_LENGTH_MSB:WAIT_LENGTH_LSB];
   assign block_enable = {large_block_select[3:0], small_block_select};

   always_ff @(posedge clock) begin
      if (reset) begin
         emulation_protect <= 1'b0;
      end else begin
         emulation_protect <= protect_now;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // CPU address path through the overlay and block decoders.
   logic        ovl_hit;
   logic [15:0] ovl_mapped;
   logic        blk_selected;

   overlay_window_decode u_overlay (
      .sel    (overlay_sel),
      .active (overlay_active),
      .addr   (cpu_access.addr),
      .hit    (ovl_hit),
      .mapped (ovl_mapped)
   );

   block_select_decode u_blocks (
      .addr     (cpu_access.addr),
      .select   (block_enable),
      .selected (blk_selected)
   );

   always_ff @(posedge clock) begin
      if (reset) begin
         cpu_to_ram         <= 1'b0;
         cpu_mapped_addr    <= 16'h0000;
         cpu_block_writable <= 1'b0;
      end else begin
         cpu_to_ram         <= cpu_access.valid & ovl_hit;
         cpu_mapped_addr    <= ovl_mapped;
         cpu_block_writable <= cpu_access.valid & blk_selected & ~protect_now
                               & flash_regs_open;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   property p_small_clear;
      @(posedge clock) disable iff (reset)
      !pins.vpp_sense |=> small_block_select == 8'h00;
   endproperty
   a_small_clear: assert property (p_small_clear)
      else $error("small-block select not cleared without voltage");

   property p_disabled_read;
      @(posedge clock) disable iff (reset)
      psel && !penable && !pwrite && hit_small && flash_disabled |=> prdata == 32'h0000_00FF;
   endproperty
   a_disabled_read: assert property (p_disabled_read)
      else $error("disabled flash register did not read all ones");

   property p_hw_standby;
      @(posedge clock) disable iff (reset)
      hardware_standby |=> overlay_wait_control == 8'h08;
   endproperty
   a_hw_standby: assert property (p_hw_standby)
      else $error("overlay register not reinitialised by standby");

   property p_sw_standby_keeps;
      @(posedge clock) disable iff (reset)
      software_standby && !hardware_standby && !(psel && penable && pwrite)
      |=> $stable(overlay_wait_control);
   endproperty
   a_sw_standby_keeps: assert property (p_sw_standby_keeps)
      else $error("overlay register changed in software standby");

   property p_protect_blocks;
      @(posedge clock) disable iff (reset)
      protect_now |=> !program_active && !erase_active;
   endproperty
   a_protect_blocks: assert property (p_protect_blocks)
      else $error("program or erase entered under protection");

   property p_verify_allowed;
      @(posedge clock) disable iff (reset)
      protect_now && flash_regs_open && !clear_flash_regs
      && flash_mode_control == 4'h4 |=> program_verify_active;
   endproperty
   a_verify_allowed: assert property (p_verify_allowed)
      else $error("program-verify refused under protection");

   property p_wait_for_interrupt;
      @(posedge clock) disable iff (reset)
      overlay_sel == OVL_ON_INTERRUPT && !overlay_triggered |=> !cpu_to_ram;
   endproperty
   a_wait_for_interrupt: assert property (p_wait_for_interrupt)
      else $error("overlay active before interrupt");

   property p_large_fixed;
      @(posedge clock) disable iff (reset)
      large_block_select[7:4] == 4'hF;
   endproperty
   a_large_fixed: assert property (p_large_fixed)
      else $error("large-block upper bits not ones");

   property p_report;
      @(posedge clock) disable iff (reset)
      psel && !penable && !pwrite && hit_report && !flash_disabled
      |=> prdata[1:0] == {1'b1, mode_zero_latched};
   endproperty
   a_report: assert property (p_report)
      else $error("mode report wrong");

   property p_program_entry;
      @(posedge clock) disable iff (reset)
      flash_mode_control == 4'h1 && !protect_now && flash_regs_open && !clear_flash_regs
      |=> program_active;
   endproperty
   a_program_entry: assert property (p_program_entry)
      else $error("program mode not entered");
endmodule : flash_block_select_ram_overlay
`default_nettype wire

// ### design/flash_ctrl_pkg.sv
/*
 Constants, types and register map of the flash block-select and RAM overlay controller.
 Assumes one 250 MHz clock, a synchronous reset and an APB master holding 32-bit data.
*/
//////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - eight small-block bits enable program and erase.
// - small-block bits clear on reset, standby, no voltage.
// - flash disabled: small-block writes ignored, reads ones.
// - overlay register resets to 08, survives software standby.
// - two overlay bits pick the RAM window.
// - one overlay bit: RAM steered, all blocks protected.
// - protection blocks program and erase, not verify.
// - both bits: overlay starts at interrupt with voltage.
// - bit 5 selects peripheral clock division.
// - bit 4 stores and reads back, resets zero.
// - wait style and length fields, reset 10 and 00.
// - large-block bits map four blocks above 1000.
// - small-block bits map eight blocks below 1000.
// - voltage plus mode pins select boot or user mode.
// - mode report shows mode 2 or 3 in boot.
// - flash registers need voltage, else read ones.
// - large-block upper nibble fixed ones, reset F0.
// - control bits 1 and 0 request erase, program.
//////////////////////////////////////////////////////////////////////////////////////////
package flash_ctrl_pkg;
   localparam int             APB_ADDR_WIDTH     = 18;
   localparam logic [15:0]    FLASH_MODE_INDEX   = 16'hFF80;
   localparam logic [15:0]    LARGE_BLOCK_INDEX  = 16'hFF82;
   localparam logic [15:0]    SMALL_BLOCK_INDEX  = 16'hFF83;
   localparam logic [15:0]    OVERLAY_WAIT_INDEX = 16'hFFC2;
   localparam logic [15:0]    MODE_REPORT_INDEX  = 16'hFFC5;
   localparam logic [1:0]     WORD_ALIGN         = 2'h0;
   localparam logic [7:0]     FLASH_MODE_RESET   = 8'h00;
   localparam logic [7:0]     LARGE_BLOCK_RESET  = 8'hF0;
   localparam logic [7:0]     SMALL_BLOCK_RESET  = 8'h00;
   localparam logic [7:0]     OVERLAY_WAIT_RESET = 8'h08;
   localparam logic [7:0]     LOCKED_READ        = 8'hFF;
   localparam logic [3:0]     LARGE_FIXED_BITS   = 4'hF;
   localparam int             VPP_STATUS_BIT     = 7;
   localparam int             ERASE_VERIFY_BIT   = 3;
   localparam int             PROGRAM_VERIFY_BIT = 2;
   localparam int             ERASE_BIT          = 1;
   localparam int             PROGRAM_BIT        = 0;
   localparam int             OVL_SEL_MSB        = 7;
   localparam int             OVL_SEL_LSB        = 6;
   localparam int             CLOCK_DIVIDE_BIT   = 5;
   localparam int             WAIT_STYLE_MSB     = 3;
   localparam int             WAIT_STYLE_LSB     = 2;
   localparam int             WAIT_LENGTH_MSB    = 1;
   localparam int             WAIT_LENGTH_LSB    = 0;
   localparam int             NUM_BLOCKS         = 12;

   typedef enum logic [1:0] {
      OVL_NONE         = 2'b00,
      OVL_LOW_WINDOW   = 2'b01,
      OVL_WIDE_WINDOW  = 2'b10,
      OVL_ON_INTERRUPT = 2'b11
   } overlay_sel_t;

   typedef enum logic [2:0] {
      OP_IDLE           = 3'b000,
      OP_PROGRAM        = 3'b001,
      OP_ERASE          = 3'b010,
      OP_PROGRAM_VERIFY = 3'b011,
      OP_ERASE_VERIFY   = 3'b100
   } flash_op_t;

   localparam logic [15:0] OVL_LOW_FLASH_FIRST  = 16'h0080;
   localparam logic [15:0] OVL_LOW_FLASH_LAST   = 16'h00FF;
   localparam logic [15:0] OVL_LOW_RAM_BASE     = 16'hFC80;
   localparam logic [15:0] OVL_WIDE_FLASH_FIRST = 16'h0080;
   localparam logic [15:0] OVL_WIDE_FLASH_LAST  = 16'h017F;
   localparam logic [15:0] OVL_WIDE_RAM_BASE    = 16'hFC80;
   localparam logic [15:0] OVL_INT_FLASH_FIRST  = 16'h0000;
   localparam logic [15:0] OVL_INT_FLASH_LAST   = 16'h007F;
   localparam logic [15:0] OVL_INT_RAM_BASE     = 16'hFC00;

   // Entries 0 to 7 are the small blocks, 8 to 11 the large blocks.
   localparam logic [NUM_BLOCKS-1:0][15:0] BLOCK_FIRST = {
      16'h6000, 16'h4000, 16'h2000, 16'h1000, 16'h0C00, 16'h0800,
      16'h0400, 16'h0200, 16'h0180, 16'h0100, 16'h0080, 16'h0000};
   localparam logic [NUM_BLOCKS-1:0][15:0] BLOCK_LAST = {
      16'h7FFF, 16'h5FFF, 16'h3FFF, 16'h1FFF, 16'h0FFF, 16'h0BFF,
      16'h07FF, 16'h03FF, 16'h01FF, 16'h017F, 16'h00FF, 16'h007F};

   typedef struct packed {
      logic vpp_sense;
      logic mode_one_hv;
      logic mode_pin_one;
      logic mode_pin_zero;
   } pin_state_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } cpu_access_t;
endpackage : flash_ctrl_pkg

// ### design/overlay_window_decode.sv
/*
 Combinational RAM overlay window decode and address substitution.
 Gates the hit with the overlay activity flag that the caller supplies.
*/
`timescale 1ns/100ps
`default_nettype none
module overlay_window_decode
   import flash_ctrl_pkg::*;
(
   input  wire overlay_sel_t sel,
   input  wire logic         active,
   input  wire logic [15:0]  addr,
   output var  logic         hit,
   output var  logic [15:0]  mapped
);
   always_comb begin
      hit    = 1'b0;
      mapped = addr;
      case (sel)
         OVL_LOW_WINDOW: begin
            hit    = addr >= OVL_LOW_FLASH_FIRST && addr <= OVL_LOW_FLASH_LAST;
            mapped = OVL_LOW_RAM_BASE + (addr - OVL_LOW_FLASH_FIRST);
         end
         OVL_WIDE_WINDOW: begin
            hit    = addr >= OVL_WIDE_FLASH_FIRST && addr <= OVL_WIDE_FLASH_LAST;
            mapped = OVL_WIDE_RAM_BASE + (addr - OVL_WIDE_FLASH_FIRST);
         end
         OVL_ON_INTERRUPT: begin
            hit    = addr <= OVL_INT_FLASH_LAST;
            mapped = OVL_INT_RAM_BASE + (addr - OVL_INT_FLASH_FIRST);
         end
         default: begin
            hit    = 1'b0;
            mapped = addr;
         end
      endcase
      hit = hit & active;
      if (!hit) begin
         mapped = addr;
      end
   end
endmodule : overlay_window_decode
`default_nettype wire

// ### tb/cpu_master.sv
/*
 APB master model standing in for the CPU software that programs the registers.
 Assumes one clock and a slave that answers each access with pready.
*/
`timescale 1ns/100ps
`default_nettype none
module cpu_master (
   input  wire logic        clock,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [17:0] paddr,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 18'h00000;
      pwdata  = 32'h00000000;
   end

   // Runs one transfer and holds it until pready is seen high at an edge.
   task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h000000, d};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~pwdata;
   endtask : xfer
endmodule : cpu_master
`default_nettype wire

// ### tb/tb.sv
/*
 Self-checking bench for the flash block-select and overlay controller.
 Assumes the APB master model and the design package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb
   import flash_ctrl_pkg::*;
;
   logic clock = 1'b0, reset, software_standby, hardware_standby, interrupt_request;
   logic psel, penable, pwrite, pready, pslverr, cpu_to_ram, cpu_block_writable, last_err;
   logic program_active, erase_active, program_verify_active, erase_verify_active;
   logic emulation_protect, peripheral_clock_divide, boot_mode, user_program_mode;
   logic flash_disabled;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] cpu_mapped_addr;
   logic [1:0]  wait_style, wait_length;
   logic [11:0] block_enable;
   pin_state_t  pins;
   cpu_access_t cpu_access;
   int bad_count = 0, samples_checked = 0, cycles = 0;

   always #2 clock = ~clock;

   cpu_master cpu (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                   .pslverr);
   flash_block_select_ram_overlay dut (.clock, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pins, .software_standby, .hardware_standby,
      .interrupt_request, .cpu_access, .cpu_to_ram, .cpu_mapped_addr, .cpu_block_writable,
      .program_active, .erase_active, .program_verify_active, .erase_verify_active,
      .emulation_protect, .peripheral_clock_divide, .wait_style, .wait_length,
      .block_enable, .boot_mode, .user_program_mode, .flash_disabled);

   //////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count = bad_count + 1;
         close_out;
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      logic [31:0] q;
      cpu.xfer(1'b1, {i, WORD_ALIGN}, d, q, last_err);
   endtask : wr

   task automatic rd(input logic [15:0] i, input logic [7:0] e);
      logic [31:0] q;
      cpu.xfer(1'b0, {i, WORD_ALIGN}, 8'h00, q, last_err);
      chk(q, {24'h000000, e});
   endtask : rd

   task automatic settle;
      repeat (2) @(posedge clock);
   endtask : settle

   task automatic start(input pin_state_t p);
      pins  <= p;
      reset <= 1'b1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      settle;
   endtask : start

   task automatic probe(input logic [15:0] a, input logic r, input logic [15:0] m);
      cpu_access <= '{valid: 1'b1, addr: a};
      repeat (2) @(posedge clock);
      chk(cpu_to_ram, r);
      chk(cpu_mapped_addr, m);
   endtask : probe

   //////////////////////////////////////////////////////////////////////////////////
   initial begin
      {software_standby, hardware_standby, interrupt_request} = 3'h0;
      cpu_access = '{valid: 1'b0, addr: 16'h0000};
      start(4'hB);
      rd(OVERLAY_WAIT_INDEX, 8'h08);
      rd(SMALL_BLOCK_INDEX, 8'h00);
      rd(LARGE_BLOCK_INDEX, 8'hF0);
      chk({wait_style, wait_length}, 4'h8);
      wr(OVERLAY_WAIT_INDEX, 8'h37);
      rd(OVERLAY_WAIT_INDEX, 8'h37);
      chk({peripheral_clock_divide, wait_style, wait_length}, 5'h17);
      wr(SMALL_BLOCK_INDEX, 8'hA5);
      wr(LARGE_BLOCK_INDEX, 8'h05);
      rd(LARGE_BLOCK_INDEX, 8'hF5);
      chk(block_enable, 12'h5A5);
      software_standby <= 1'b1;
      settle;
      software_standby <= 1'b0;
      rd(OVERLAY_WAIT_INDEX, 8'h37);
      rd(SMALL_BLOCK_INDEX, 8'h00);
      wr(SMALL_BLOCK_INDEX, 8'h0F);
      pins.vpp_sense <= 1'b0;
      settle;
      rd(SMALL_BLOCK_INDEX, 8'hFF);
      pins.vpp_sense <= 1'b1;
      settle;
      rd(SMALL_BLOCK_INDEX, 8'h00);
      hardware_standby <= 1'b1;
      settle;
      hardware_standby <= 1'b0;
      rd(OVERLAY_WAIT_INDEX, 8'h08);
      wr(OVERLAY_WAIT_INDEX, 8'h48);
      settle;
      probe(16'h00C0, 1'b1, 16'hFCC0);
      probe(16'h0170, 1'b0, 16'h0170);
      chk(emulation_protect, 1'b1);
      wr(FLASH_MODE_INDEX, 8'h01);
      settle;
      chk(program_active, 1'b0);
      wr(FLASH_MODE_INDEX, 8'h04);
      settle;
      chk(program_verify_active, 1'b1);
      wr(OVERLAY_WAIT_INDEX, 8'h88);
      settle;
      probe(16'h0170, 1'b1, 16'hFD70);
      wr(FLASH_MODE_INDEX, 8'h02);
      settle;
      chk(erase_active, 1'b0);
      wr(OVERLAY_WAIT_INDEX, 8'hC8);
      settle;
      probe(16'h0010, 1'b0, 16'h0010);
      interrupt_request <= 1'b1;
      settle;
      interrupt_request <= 1'b0;
      probe(16'h0010, 1'b1, 16'hFC10);
      wr(OVERLAY_WAIT_INDEX, 8'h08);
      wr(FLASH_MODE_INDEX, 8'h01);
      settle;
      chk(program_active, 1'b1);
      wr(FLASH_MODE_INDEX, 8'h02);
      settle;
      chk(erase_active, 1'b1);
      wr(FLASH_MODE_INDEX, 8'h08);
      wr(SMALL_BLOCK_INDEX, 8'h10);
      settle;
      chk(erase_verify_active, 1'b1);
      probe(16'h0300, 1'b0, 16'h0300);
      chk(cpu_block_writable, 1'b1);
      probe(16'h0400, 1'b0, 16'h0400);
      chk(cpu_block_writable, 1'b0);
      rd(16'hFF00, 8'h00);
      chk(last_err, 1'b1);
      start(4'hE);
      chk(boot_mode, 1'b1);
      rd(MODE_REPORT_INDEX, 8'h02);
      pins.vpp_sense <= 1'b0;
      settle;
      rd(SMALL_BLOCK_INDEX, 8'hFF);
      chk(last_err, 1'b1);
      start(4'hB);
      chk(user_program_mode, 1'b1);
      start(4'h1);
      chk(flash_disabled, 1'b1);
      wr(SMALL_BLOCK_INDEX, 8'h3C);
      rd(SMALL_BLOCK_INDEX, 8'hFF);
      close_out;
   end
endmodule : tb
`default_nettype wire
